// ---- verilog/stop_mode_pkg.sv ----
// Package with register map, field layouts, reset values and timing for the stop-mode block.
`default_nettype none
package stop_mode_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_MAINS_STOP   = 8'h00;
  localparam logic [7:0] OFS_ALARM_STOP   = 8'h04;
  localparam logic [7:0] OFS_SERVO_STOP   = 8'h08;
  localparam logic [7:0] OFS_BRAKE_DELAY  = 8'h0c;
  localparam logic [7:0] OFS_UV_SELECT    = 8'h10;
  localparam logic [7:0] OFS_ESTOP_TORQUE = 8'h14;
  localparam logic [7:0] OFS_CONTROL      = 8'h18;
  localparam logic [7:0] OFS_STATUS       = 8'h1c;
  // Field widths and limits.
  localparam int          SEL9_W          = 4;
  localparam int          SEL3_W          = 2;
  localparam int          DELAY_W         = 7;
  localparam int          TORQUE_W        = 9;
  localparam logic [3:0]  SEL9_MAX        = 4'h9;
  localparam logic [6:0]  DELAY_MAX       = 7'h64;
  localparam logic [8:0]  TORQUE_MAX      = 9'h1f4;
  // Reset values.
  localparam logic [3:0]  MAINS_STOP_RST  = 4'h0;
  localparam logic [1:0]  ALARM_STOP_RST  = 2'h0;
  localparam logic [3:0]  SERVO_STOP_RST  = 4'h0;
  localparam logic [6:0]  BRAKE_DELAY_RST = 7'h0a;
  localparam logic [0:0]  UV_SELECT_RST   = 1'h1;
  localparam logic [8:0]  ESTOP_TORQ_RST  = 9'h000;
  // Control register bit positions.
  localparam int          CTL_RUN_BIT     = 0;
  localparam int          CTL_ALARM_BIT   = 1;
  localparam int          CTL_MAINS_BIT   = 2;
  localparam int          CTL_STOPPED_BIT = 3;
  // Timing: 2 ms tick at 250 MHz.
  localparam int          CLK_HZ          = 250_000_000;
  localparam int          TICK_MS         = 2;
  localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  // Deceleration action codes.
  typedef enum logic [1:0] {DECEL_DYN_BRAKE = 2'h0, DECEL_FREE_RUN = 2'h1,
                            DECEL_ESTOP = 2'h2} decel_type;
  // Sequencer states, Gray coded along run, brake drop, wait, off.
  typedef enum logic [1:0] {ST_RUN = 2'b00, ST_BRAKE = 2'b01, ST_WAIT = 2'b11,
                            ST_OFF = 2'b10} seq_state_type;
  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage
`default_nettype wire

// ---- verilog/stop_decode.sv ----
// Decoder for one zero-to-nine stop selection setting.
`default_nettype none
module stop_decode (
  // Setting in.
  input  wire logic [3:0] sel,
  // Decoded actions.
  output logic [1:0]      decel,
  output logic            after_free,
  output logic            dev_hold
);
  // Values 8 and 9 use emergency stop; below that even values brake and odd ones free run.
  always_comb begin
    if (sel >= 4'h8) begin
      decel = stop_mode_pkg::DECEL_ESTOP;
    end else if (sel[0]) begin
      decel = stop_mode_pkg::DECEL_FREE_RUN;
    end else begin
      decel = stop_mode_pkg::DECEL_DYN_BRAKE;
    end
    after_free = (sel >= 4'h8) ? sel[0] : sel[1];
    dev_hold   = (sel >= 4'h4) && (sel <= 4'h7);
  end
endmodule
`default_nettype wire

// ---- verilog/stop_mode_ctrl.sv ----
// Stop-mode selection and stopped-brake timing with an AXI4-Lite register slave.
`default_nettype none
// What this block does
// - Mains-off setting: dynamic brake for 0,2,4,6, free run for 1,3,5,7, e-stop for 8,9.
// - Mains-off setting brakes after stop for 0,1,4,5,8 and leaves the motor free for 2,3,6,7,9.
// - Mains-off setting holds the deviation counter for 4 to 7 and clears it otherwise.
// - The mains-off setting takes 0 to 9 and resets to 0, meaning brake, brake and clear.
// - On an alarm the 0 to 3 alarm setting picks brake or free run, then brake or servo free.
// - A run on-to-off transition decodes the servo-off setting exactly like the mains-off one.
// - With the motor stopped and run removed, the brake interlock drops before de-energising.
// - Brake drop to de-energise takes the 0 to 100 delay setting times 2 ms, default 10.
// - The mains-off selection applies only when the undervoltage alarm select is 0.
// - Emergency-stop deceleration limits torque to the configured emergency stop torque.
module stop_mode_ctrl (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // AXI4-Lite write address.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Drive status inputs.
  input  wire logic        run_cmd,
  input  wire logic        alarm_active,
  input  wire logic        mains_lost,
  input  wire logic        motor_stopped,
  // Drive actions.
  output logic             brake_interlock_out,
  output logic             motor_energise,
  output logic [1:0]       decel_action,
  output logic             after_stop_free,
  output logic             deviation_hold,
  output logic             torque_limit_en,
  output logic [8:0]       torque_limit_pct
);
  // Setting registers.
  logic [3:0] mains_off_stop_select;
  logic [1:0] alarm_stop_select;
  logic [3:0] servo_off_stop_select;
  logic [6:0] stopped_brake_delay;
  logic       undervoltage_alarm_select;
  logic [8:0] emergency_stop_torque_limit;
  // Bus state.
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // Sequencer state.
  stop_mode_pkg::seq_state_type state;
  logic [6:0] delay_count;
  logic [27:0] tick_div;
  logic       tick;
  logic       run_prev;
  logic       stopping;
  logic       stop_source_servo;
  // Decoded settings.
  logic [1:0] mains_decel;
  logic       mains_free;
  logic       mains_hold;
  logic [1:0] servo_decel;
  logic       servo_free;
  logic       servo_hold;
  logic       mains_stop_active;

  stop_decode u_mains_decode (
    .sel        (mains_off_stop_select),
    .decel      (mains_decel),
    .after_free (mains_free),
    .dev_hold   (mains_hold)
  );

  stop_decode u_servo_decode (
    .sel        (servo_off_stop_select),
    .decel      (servo_decel),
    .after_free (servo_free),
    .dev_hold   (servo_hold)
  );

  // Address and data are caught in either order; the response waits for both.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Capture of the write address and data halves.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Register writes; out-of-range mains, servo-off, delay and torque values are refused with SLVERR and leave the setting alone.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mains_off_stop_select       <= stop_mode_pkg::MAINS_STOP_RST;
      alarm_stop_select           <= stop_mode_pkg::ALARM_STOP_RST;
      servo_off_stop_select       <= stop_mode_pkg::SERVO_STOP_RST;
      stopped_brake_delay         <= stop_mode_pkg::BRAKE_DELAY_RST;
      undervoltage_alarm_select   <= stop_mode_pkg::UV_SELECT_RST;
      emergency_stop_torque_limit <= stop_mode_pkg::ESTOP_TORQ_RST;
      s_axi_bvalid                <= 1'b0;
      s_axi_bresp                 <= stop_mode_pkg::RESP_OKAY;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= stop_mode_pkg::RESP_OKAY;
      unique case (aw_addr)
        stop_mode_pkg::OFS_MAINS_STOP: begin
          if (w_data[31:4] != 28'h0 || w_data[3:0] > stop_mode_pkg::SEL9_MAX) begin
            s_axi_bresp <= stop_mode_pkg::RESP_SLVERR;
          end else if (w_strb[0]) begin
            mains_off_stop_select <= w_data[3:0];
          end
        end
        stop_mode_pkg::OFS_ALARM_STOP: begin
          if (w_strb[0]) begin
            alarm_stop_select <= w_data[1:0];
          end
        end
        stop_mode_pkg::OFS_SERVO_STOP: begin
          if (w_data[31:4] != 28'h0 || w_data[3:0] > stop_mode_pkg::SEL9_MAX) begin
            s_axi_bresp <= stop_mode_pkg::RESP_SLVERR;
          end else if (w_strb[0]) begin
            servo_off_stop_select <= w_data[3:0];
          end
        end
        stop_mode_pkg::OFS_BRAKE_DELAY: begin
          if (w_data[31:7] != 25'h0 || w_data[6:0] > stop_mode_pkg::DELAY_MAX) begin
            s_axi_bresp <= stop_mode_pkg::RESP_SLVERR;
          end else if (w_strb[0]) begin
            stopped_brake_delay <= w_data[6:0];
          end
        end
        stop_mode_pkg::OFS_UV_SELECT: begin
          if (w_strb[0]) begin
            undervoltage_alarm_select <= w_data[0];
          end
        end
        stop_mode_pkg::OFS_ESTOP_TORQUE: begin
          if (w_data[31:9] != 23'h0 || w_data[8:0] > stop_mode_pkg::TORQUE_MAX) begin
            s_axi_bresp <= stop_mode_pkg::RESP_SLVERR;
          end else if (w_strb[1:0] == 2'h3) begin
            emergency_stop_torque_limit <= w_data[8:0];
          end
        end
        default: begin
          s_axi_bresp <= stop_mode_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path; the status word shows the delay count, sequencer state, brake interlock and energise outputs.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= stop_mode_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= stop_mode_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        stop_mode_pkg::OFS_MAINS_STOP:   s_axi_rdata <= {28'h0, mains_off_stop_select};
        stop_mode_pkg::OFS_ALARM_STOP:   s_axi_rdata <= {30'h0, alarm_stop_select};
        stop_mode_pkg::OFS_SERVO_STOP:   s_axi_rdata <= {28'h0, servo_off_stop_select};
        stop_mode_pkg::OFS_BRAKE_DELAY:  s_axi_rdata <= {25'h0, stopped_brake_delay};
        stop_mode_pkg::OFS_UV_SELECT:    s_axi_rdata <= {31'h0, undervoltage_alarm_select};
        stop_mode_pkg::OFS_ESTOP_TORQUE: s_axi_rdata <= {23'h0, emergency_stop_torque_limit};
        stop_mode_pkg::OFS_CONTROL:
          s_axi_rdata <= {28'h0, motor_stopped, mains_lost, alarm_active, run_cmd};
        stop_mode_pkg::OFS_STATUS:
          s_axi_rdata <= {21'h0, delay_count, state, brake_interlock_out, motor_energise};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= stop_mode_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Free-running divider giving a one-cycle pulse every 2 ms.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_div <= 28'h0;
      tick     <= 1'b0;
    end else if (tick_div == 28'(stop_mode_pkg::TICK_CYCLES - 1)) begin
      tick_div <= 28'h0;
      tick     <= 1'b1;
    end else begin
      tick_div <= tick_div + 28'h1;
      tick     <= 1'b0;
    end
  end

  // Mains-off handling only counts while the undervoltage alarm is not selected.
  assign mains_stop_active = mains_lost && !undervoltage_alarm_select;

  // Remembers a servo-off stop, started on the run falling edge, until run returns.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_prev          <= 1'b0;
      stop_source_servo <= 1'b0;
    end else begin
      run_prev <= run_cmd;
      if (run_cmd) begin
        stop_source_servo <= 1'b0;
      end else if (run_prev) begin
        stop_source_servo <= 1'b1;
      end
    end
  end

  assign stopping = alarm_active || mains_stop_active || stop_source_servo;

  // Action select: alarm beats mains loss, which beats servo-off.
  always_comb begin
    decel_action    = stop_mode_pkg::DECEL_DYN_BRAKE;
    after_stop_free = 1'b0;
    deviation_hold  = 1'b0;
    if (alarm_active) begin
      decel_action    = alarm_stop_select[0] ? stop_mode_pkg::DECEL_FREE_RUN
                                             : stop_mode_pkg::DECEL_DYN_BRAKE;
      after_stop_free = alarm_stop_select[1];
    end else if (mains_stop_active) begin
      decel_action    = mains_decel;
      after_stop_free = mains_free;
      deviation_hold  = mains_hold;
    end else if (stop_source_servo) begin
      decel_action    = servo_decel;
      after_stop_free = servo_free;
      deviation_hold  = servo_hold;
    end
  end

  // Torque clamp during emergency-stop deceleration.
  assign torque_limit_en  = stopping && (decel_action == stop_mode_pkg::DECEL_ESTOP);
  assign torque_limit_pct = emergency_stop_torque_limit;

  // Stopped-brake sequencer. The delay is counted in whole ticks, so the first
  // interval can be short by up to one tick since the divider runs free.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state               <= stop_mode_pkg::ST_RUN;
      delay_count         <= 7'h00;
      brake_interlock_out <= 1'b0;
      motor_energise      <= 1'b0;
    end else begin
      unique case (state)
        stop_mode_pkg::ST_RUN: begin
          // A run drop on a stopped motor hands over to the sequence with both outputs
          // held, so the motor can never lose power before the brake has engaged.
          if (run_prev && !run_cmd && motor_stopped) begin
            state <= stop_mode_pkg::ST_BRAKE;
          end else begin
            brake_interlock_out <= run_cmd;
            motor_energise      <= run_cmd;
          end
        end
        stop_mode_pkg::ST_BRAKE: begin
          brake_interlock_out <= 1'b0;
          delay_count         <= stopped_brake_delay;
          state               <= stop_mode_pkg::ST_WAIT;
        end
        stop_mode_pkg::ST_WAIT: begin
          if (delay_count == 7'h00) begin
            motor_energise <= 1'b0;
            state          <= stop_mode_pkg::ST_OFF;
          end else if (tick) begin
            delay_count <= delay_count - 7'h01;
          end
        end
        stop_mode_pkg::ST_OFF: begin
          if (run_cmd) begin
            state <= stop_mode_pkg::ST_RUN;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verification/stop_mode_props.sv ----
// Checker of the stop-mode block's behaviour at its ports.
`default_nettype none
module stop_mode_props (
  // Clock and reset.
  input wire logic       clk_sys,
  input wire logic       arst_n,
  // Bus handshakes.
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Drive signals.
  input wire logic       run_cmd,
  input wire logic       motor_stopped,
  input wire logic       brake_interlock_out,
  input wire logic       motor_energise,
  input wire logic [1:0] decel_action,
  input wire logic       deviation_hold,
  input wire logic       torque_limit_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  decel_code_a: assert property (decel_action != 2'h3)
    else $error("deceleration action holds an unused code");
  estop_clear_a: assert property (
      decel_action == stop_mode_pkg::DECEL_ESTOP |-> !deviation_hold)
    else $error("emergency stop holds the deviation counter");
  estop_torque_a: assert property (
      torque_limit_en |-> decel_action == stop_mode_pkg::DECEL_ESTOP)
    else $error("torque limit active without emergency stop");
  brake_first_a: assert property (
      $fell(brake_interlock_out) && motor_stopped |-> motor_energise)
    else $error("motor de-energised no later than the brake drop");
  energise_after_a: assert property (
      $fell(motor_energise) && motor_stopped |-> !$past(brake_interlock_out))
    else $error("energise dropped while the brake was still released");
  brake_cause_a: assert property ($rose(brake_interlock_out) |-> $past(run_cmd))
    else $error("brake released without a run command");
  // The response must come exactly two cycles after the address and data are taken.
  wr_answer_a: assert property ($rose(s_axi_bvalid) |->
      $past(s_axi_awvalid && s_axi_awready, 2) || $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("write response not two cycles after the handshake");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not valid one cycle after the address");
endmodule
bind stop_mode_ctrl stop_mode_props u_props (
  .clk_sys, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .run_cmd, .motor_stopped,
  .brake_interlock_out, .motor_energise, .decel_action, .deviation_hold, .torque_limit_en
);
`default_nettype wire

// ---- verification/host_model.sv ----
// Host controller model that drives the run command into the drive.
`default_nettype none
module host_model #(
  parameter int LAG = 1
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Request from the sequence and the run level the drive sees.
  input  wire logic run_req,
  output logic      run_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pipe;
  // A delay line lets the same model act as a prompt or a slow host.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pipe <= 8'h00;
    end else begin
      pipe <= {pipe[6:0], run_req};
    end
  end
  assign run_cmd = pipe[LAG - 1];
endmodule
`default_nettype wire

// ---- verification/test_servo_stop_mode_and_brake_timing.sv ----
// Directed testbench for the stop-mode block.
`default_nettype none
module test_servo_stop_mode_and_brake_timing;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and bus signals.
  logic        clk_sys = 1'b0, arst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, decel_action, resp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  // Drive-side signals.
  logic        run_req = 1'b0, alarm_active = 1'b0, mains_lost = 1'b0, motor_stopped = 1'b0;
  logic        run_cmd, brake_interlock_out, motor_energise;
  logic        after_stop_free, deviation_hold, torque_limit_en;
  logic [8:0]  torque_limit_pct;
  int          bad_count = 0, n_tests = 0, cyc = 0, t_brake, t_off;
  always #2 clk_sys = ~clk_sys;
  // The host runs two cycles behind the request, as a slow controller would.
  host_model #(.LAG(2)) u_host (.clk_sys, .arst_n, .run_req, .run_cmd);
  stop_mode_ctrl uut (
    .clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .run_cmd, .alarm_active, .mains_lost, .motor_stopped,
    .brake_interlock_out, .motor_energise, .decel_action, .after_stop_free,
    .deviation_hold, .torque_limit_en, .torque_limit_pct
  );
  // Compares a seen value with its expectation and logs any mismatch.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One write; each channel is released at the edge its ready is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p;
    logic w_p;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(posedge clk_sys);
      if (aw_p && s_axi_awready === 1'b1) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // One read; data and response are taken at the edge rvalid is seen.
  task automatic rdreg(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Lets the slow host and the decode settle before outputs are sampled.
  task automatic settle();
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  // Checks the three decoded actions against the zero-to-nine table.
  task automatic check_sel9(input logic [3:0] s);
    check("decel", decel_action, s[3] ? stop_mode_pkg::DECEL_ESTOP : {1'b0, s[0]});
    check("after stop", after_stop_free, (s > 4'h7) ? s[0] : s[1]);
    check("dev hold", deviation_hold, s inside {[4'h4:4'h7]});
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hang is cut short well past the few hundred cycles the sequence needs.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    // The mains, alarm, servo-off and delay settings come out of reset at their defaults; a hole answers with an error.
    for (int i = 0; i < 4; i++) begin
      rdreg(stop_mode_pkg::OFS_MAINS_STOP + 8'(4 * i));
      check("reset value", rd, (i == 3) ? 32'h0a : 32'h0);
    end
    rdreg(8'h20);
    check("unmapped", resp, stop_mode_pkg::RESP_SLVERR);
    // Mains loss with the undervoltage alarm off walks every mains setting.
    wr(stop_mode_pkg::OFS_ESTOP_TORQUE, 32'h1f4);
    wr(stop_mode_pkg::OFS_UV_SELECT, 32'h0);
    @(posedge clk_sys) begin
      mains_lost <= 1'b1;
      run_req <= 1'b1;
    end
    for (int i = 0; i < 10; i++) begin
      wr(stop_mode_pkg::OFS_MAINS_STOP, 32'(i));
      settle();
      check_sel9(4'(i));
      check("torque en", torque_limit_en, i > 7);
      check("torque pct", torque_limit_pct, 32'h1f4);
    end
    wr(stop_mode_pkg::OFS_MAINS_STOP, 32'h0a);
    check("range resp", resp, stop_mode_pkg::RESP_SLVERR);
    rdreg(stop_mode_pkg::OFS_MAINS_STOP);
    check("range keep", rd, 32'h9);
    // An alarm overrides the mains setting.
    @(posedge clk_sys) alarm_active <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(stop_mode_pkg::OFS_ALARM_STOP, 32'(i));
      settle();
      check("alarm decel", decel_action, 2'(i & 1));
      check("alarm after", after_stop_free, i > 1);
    end
    @(posedge clk_sys) alarm_active <= 1'b0;
    // With the undervoltage alarm on, the mains setting must not apply.
    wr(stop_mode_pkg::OFS_UV_SELECT, 32'h1);
    @(posedge clk_sys) run_req <= 1'b0;
    settle();
    check("uv gate", decel_action, stop_mode_pkg::DECEL_DYN_BRAKE);
    @(posedge clk_sys) mains_lost <= 1'b0;
    // Each servo-off setting is applied on a run drop of a moving motor.
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys) run_req <= 1'b1;
      wr(stop_mode_pkg::OFS_SERVO_STOP, 32'(i));
      @(posedge clk_sys) run_req <= 1'b0;
      settle();
      check_sel9(4'(i));
    end
    // Stopped motor with no delay: brake drops one edge before de-energise.
    wr(stop_mode_pkg::OFS_BRAKE_DELAY, 32'h0);
    @(posedge clk_sys) begin
      motor_stopped <= 1'b1;
      run_req <= 1'b1;
    end
    settle();
    check("brake on", brake_interlock_out, 1'b1);
    check("energised", motor_energise, 1'b1);
    @(posedge clk_sys) run_req <= 1'b0;
    t_brake = 0;
    t_off = 0;
    for (int k = 1; k < 12; k++) begin
      @(posedge clk_sys);
      #1;
      if (t_brake == 0 && brake_interlock_out === 1'b0) t_brake = k;
      if (t_off == 0 && motor_energise === 1'b0) t_off = k;
    end
    check("brake seen", t_brake > 0, 1'b1);
    check("off gap", t_off - t_brake, 1);
    // A long delay parks the loaded count in the status word; no tick falls in this run,
    // so the motor must stay energised while the sequencer waits.
    @(posedge clk_sys) run_req <= 1'b1;
    settle();
    check("brake back", brake_interlock_out, 1'b1);
    wr(stop_mode_pkg::OFS_BRAKE_DELAY, 32'h64);
    check("delay resp", resp, stop_mode_pkg::RESP_OKAY);
    @(posedge clk_sys) run_req <= 1'b0;
    settle();
    rdreg(stop_mode_pkg::OFS_STATUS);
    check("delay wait", rd, {21'h0, 7'h64, stop_mode_pkg::ST_WAIT, 2'b01});
    check("still on", motor_energise, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
